/* src/dic_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin levels, one clock
module dic_pin_sync
  import dic_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      level_reg <= '0;
    else
      level_reg <= (s2_reg & s3_reg) | (level_reg & (s2_reg | s3_reg));
  end

  assign o_level = level_reg;

  a_sync_agree : assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s2_reg == s3_reg) |=> (level_reg == $past(s3_reg)))
    else $error("level did not follow agreeing stages");

endmodule

/* src/dic_pkg.sv */
// constants, indexes and types of the digital input conditioning block
// assumes one system clock and an object-dictionary style register port
// Summary of operation
// - mask bits 0..2 enable limit/home functions
// - mask bits 16..31 never affect inputs
// - invert bit 1 reports high level as 0
// - inversion skips step clock/direction inputs in step/direction mode
// - force enable replaces physical level by software
// - force value used only where enabled
// - range bit selects low or high threshold
// - routing enable chooses routed or direct state
// - capture encoder position on input 1 change
// - edge code: off, rise, fall, both
// - counter counts changes, cleared writing 1..3
package dic_pkg;

  // register indexes (subindex of the control object)
  localparam logic [7:0] IDX_HIGHEST   = 8'h00;
  localparam logic [7:0] IDX_SF_MASK   = 8'h01;
  localparam logic [7:0] IDX_INV_MASK  = 8'h02;
  localparam logic [7:0] IDX_OVR_EN    = 8'h03;
  localparam logic [7:0] IDX_OVR_LVL   = 8'h04;
  localparam logic [7:0] IDX_RAW       = 8'h05;
  localparam logic [7:0] IDX_RANGE     = 8'h06;
  localparam logic [7:0] IDX_DIFF      = 8'h07;
  localparam logic [7:0] IDX_ROUTE     = 8'h08;
  localparam logic [7:0] IDX_CAP_CTRL  = 8'h11;
  localparam logic [7:0] IDX_CAP_COUNT = 8'h12;
  localparam logic [7:0] IDX_CAP_VALUE = 8'h13;

  // values after reset
  localparam logic [7:0]  HIGHEST_RST = 8'h08;
  localparam logic [31:0] WORD_RST    = 32'h0;

  // special-function mask bits and the inputs they watch
  localparam int SF_NEG_BIT  = 0;
  localparam int SF_POS_BIT  = 1;
  localparam int SF_HOME_BIT = 2;
  localparam int NEG_INPUT   = 0;
  localparam int POS_INPUT   = 1;
  localparam int HOME_INPUT  = 2;

  // step-direction inputs exempt from inversion, capture input
  localparam int STEP_CLK_INPUT = 0;
  localparam int STEP_DIR_INPUT = 1;
  localparam int CAP_INPUT      = 0;

  // synchroniser flip-flops in the pin synchroniser, not counting its agreement filter register
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0]
  {
    CAP_OFF  = 2'b00,
    CAP_RISE = 2'b01,
    CAP_FALL = 2'b10,
    CAP_BOTH = 2'b11
  } dic_cap_mode_type;

endpackage

/* src/dic_top.sv */
// digital input conditioning: force, invert, route, special functions,
// threshold and receiver selects, edge capture on input 1
// assumes asynchronous pin levels, a routed level vector from the
// routing stage, and an encoder position on the same clock
module dic_top
  import dic_pkg::*;
#(
  parameter int N_IN = 16
)
(
  input  wire logic [N_IN-1:0] i_pin_level,
  input  wire logic            i_clk,
  input  wire logic            i_nrst,
  input  wire logic            i_step_dir_mode,
  input  wire logic [N_IN-1:0] i_routed_level,
  input  wire logic [31:0]     i_enc_position,
  input  wire logic            i_reg_wr,
  input  wire logic [7:0]      i_reg_index,
  input  wire logic [31:0]     i_reg_wdata,
  output logic      [31:0]     o_reg_rdata,
  output logic      [N_IN-1:0] o_input_state,
  output logic                 o_neg_limit,
  output logic                 o_pos_limit,
  output logic                 o_home_switch,
  output logic      [N_IN-1:0] o_thresh_high,
  output logic                 o_diff_receive,
  output logic                 o_route_enable,
  output logic                 o_capture_pulse
);

  logic [31:0]      sf_mask_reg;
  logic [31:0]      inv_mask_reg;
  logic [31:0]      ovr_en_reg;
  logic [31:0]      ovr_lvl_reg;
  logic [31:0]      range_reg;
  logic [31:0]      diff_reg;
  logic [31:0]      route_reg;
  dic_cap_mode_type cap_mode_reg;
  logic [31:0]      cap_count_reg;
  logic [31:0]      cap_value_reg;
  logic             cap_prev_reg;
  logic             cap_pulse_reg;
  logic [N_IN-1:0]  cond_reg;
  logic [N_IN-1:0]  state_reg;
  logic             neg_reg;
  logic             pos_reg;
  logic             home_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic [N_IN-1:0]  phys_level;
  logic [N_IN-1:0]  forced_level;
  logic [N_IN-1:0]  inv_eff;
  logic [N_IN-1:0]  cond_next;
  logic             cap_rise;
  logic             cap_fall;
  logic             cap_hit;
  logic             cap_clear;
  logic             ctrl_valid;

  dic_pin_sync #(
    .W (N_IN)
  ) u_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async (i_pin_level),
    .o_level (phys_level)
  );

  function automatic logic hit(input logic [7:0] idx);
    hit = i_reg_wr && (i_reg_index == idx);
  endfunction

  // configuration registers
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sf_mask_reg  <= WORD_RST;
      inv_mask_reg <= WORD_RST;
      ovr_en_reg   <= WORD_RST;
      ovr_lvl_reg  <= WORD_RST;
      range_reg    <= WORD_RST;
      diff_reg     <= WORD_RST;
      route_reg    <= WORD_RST;
    end
    else
    begin
      if (hit(IDX_SF_MASK))
        sf_mask_reg <= i_reg_wdata;
      if (hit(IDX_INV_MASK))
        inv_mask_reg <= i_reg_wdata;
      if (hit(IDX_OVR_EN))
        ovr_en_reg <= i_reg_wdata;
      if (hit(IDX_OVR_LVL))
        ovr_lvl_reg <= i_reg_wdata;
      if (hit(IDX_RANGE))
        range_reg <= i_reg_wdata;
      if (hit(IDX_DIFF))
        diff_reg <= i_reg_wdata;
      if (hit(IDX_ROUTE))
        route_reg <= i_reg_wdata;
    end
  end

  // conditioning path
  always_comb
  begin
    forced_level = (ovr_en_reg[N_IN-1:0] & ovr_lvl_reg[N_IN-1:0])
                 | (~ovr_en_reg[N_IN-1:0] & phys_level);
    inv_eff = inv_mask_reg[N_IN-1:0];
    if (i_step_dir_mode)
    begin
      inv_eff[STEP_CLK_INPUT] = 1'b0;
      inv_eff[STEP_DIR_INPUT] = 1'b0;
    end
    cond_next = forced_level ^ inv_eff;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cond_reg <= '0;
    else
      cond_reg <= cond_next;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      state_reg <= '0;
    else if (route_reg[0])
      state_reg <= i_routed_level;
    else
      state_reg <= cond_reg;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      neg_reg  <= 1'b0;
      pos_reg  <= 1'b0;
      home_reg <= 1'b0;
    end
    else
    begin
      neg_reg  <= sf_mask_reg[SF_NEG_BIT] & cond_reg[NEG_INPUT];
      pos_reg  <= sf_mask_reg[SF_POS_BIT] & cond_reg[POS_INPUT];
      home_reg <= sf_mask_reg[SF_HOME_BIT] & cond_reg[HOME_INPUT];
    end
  end

  // capture edge detection on input 1
  assign cap_rise   = cond_reg[CAP_INPUT] & ~cap_prev_reg;
  assign cap_fall   = ~cond_reg[CAP_INPUT] & cap_prev_reg;
  assign ctrl_valid = (i_reg_wdata[31:2] == 30'h0);
  assign cap_clear  = hit(IDX_CAP_CTRL) && ctrl_valid && (i_reg_wdata[1:0] != 2'h0);

  always_comb
  begin
    case (cap_mode_reg)
      CAP_OFF:  cap_hit = 1'b0;
      CAP_RISE: cap_hit = cap_rise;
      CAP_FALL: cap_hit = cap_fall;
      CAP_BOTH: cap_hit = cap_rise | cap_fall;
      default:  cap_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cap_mode_reg <= CAP_OFF;
      cap_prev_reg <= 1'b0;
    end
    else
    begin
      cap_prev_reg <= cond_reg[CAP_INPUT];
      if (hit(IDX_CAP_CTRL) && ctrl_valid)
        cap_mode_reg <= dic_cap_mode_type'(i_reg_wdata[1:0]);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cap_count_reg <= WORD_RST;
    else if (cap_hit)
      cap_count_reg <= cap_clear ? 32'h1 : cap_count_reg + 32'h1;
    else if (cap_clear)
      cap_count_reg <= 32'h0;
    else if (hit(IDX_CAP_COUNT))
      cap_count_reg <= i_reg_wdata;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cap_value_reg <= WORD_RST;
      cap_pulse_reg <= 1'b0;
    end
    else
    begin
      cap_pulse_reg <= cap_hit;
      if (cap_hit)
        cap_value_reg <= i_enc_position;
      else if (hit(IDX_CAP_VALUE))
        cap_value_reg <= i_reg_wdata;
    end
  end

  // register read mux
  always_comb
  begin
    rdata_next = 32'h0;
    case (i_reg_index)
      IDX_HIGHEST:   rdata_next = {24'h0, HIGHEST_RST};
      IDX_SF_MASK:   rdata_next = sf_mask_reg;
      IDX_INV_MASK:  rdata_next = inv_mask_reg;
      IDX_OVR_EN:    rdata_next = ovr_en_reg;
      IDX_OVR_LVL:   rdata_next = ovr_lvl_reg;
      IDX_RAW:       rdata_next = 32'(phys_level);
      IDX_RANGE:     rdata_next = range_reg;
      IDX_DIFF:      rdata_next = diff_reg;
      IDX_ROUTE:     rdata_next = route_reg;
      IDX_CAP_CTRL:  rdata_next = {30'h0, cap_mode_reg};
      IDX_CAP_COUNT: rdata_next = cap_count_reg;
      IDX_CAP_VALUE: rdata_next = cap_value_reg;
      default:       rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_reg <= WORD_RST;
    else
      rdata_reg <= rdata_next;
  end

  assign o_reg_rdata     = rdata_reg;
  assign o_input_state   = state_reg;
  assign o_neg_limit     = neg_reg;
  assign o_pos_limit     = pos_reg;
  assign o_home_switch   = home_reg;
  assign o_thresh_high   = range_reg[N_IN-1:0];
  assign o_diff_receive  = diff_reg[0];
  assign o_route_enable  = route_reg[0];
  assign o_capture_pulse = cap_pulse_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_force_applied : assert property (
    (ovr_en_reg[3] && !inv_mask_reg[3]) |=> (cond_reg[3] == $past(ovr_lvl_reg[3])))
    else $error("forced level not applied");

  a_pin_passes : assert property (
    (!ovr_en_reg[3] && !inv_mask_reg[3]) |=> (cond_reg[3] == $past(phys_level[3])))
    else $error("physical level not passed");

  a_force_inverted : assert property (
    (ovr_en_reg[2] && inv_mask_reg[2]) |=> (cond_reg[2] != $past(ovr_lvl_reg[2])))
    else $error("inversion not applied after forcing");

  a_stepdir_exempt : assert property (
    (i_step_dir_mode && ovr_en_reg[1]) |=> (cond_reg[1] == $past(ovr_lvl_reg[1])))
    else $error("step input was inverted");

  a_sf_gated : assert property (
    (sf_mask_reg[2:0] == 3'h0) |=> !(o_neg_limit || o_pos_limit || o_home_switch))
    else $error("special function active while disabled");

  a_home_follows : assert property (
    (sf_mask_reg[SF_HOME_BIT] && ovr_en_reg[HOME_INPUT]) ##1 sf_mask_reg[SF_HOME_BIT]
      |=> (o_home_switch == $past(cond_reg[HOME_INPUT])))
    else $error("home output wrong");

  a_route_bypass : assert property (
    !route_reg[0] |=> (o_input_state == $past(cond_reg)))
    else $error("state not from conditioned level");

  a_route_used : assert property (
    route_reg[0] |=> (o_input_state == $past(i_routed_level)))
    else $error("state not from routed level");

  a_range_write : assert property (
    hit(IDX_RANGE) |=> (o_thresh_high == $past(i_reg_wdata[N_IN-1:0])))
    else $error("threshold select not updated");

  a_diff_write : assert property (
    hit(IDX_DIFF) |=> (o_diff_receive == $past(i_reg_wdata[0])))
    else $error("differential select not updated");

  a_cap_clear : assert property (
    (cap_clear && !cap_hit) |=> (cap_count_reg == 32'h0))
    else $error("capture count not cleared");

  a_cap_latch : assert property (
    (cap_hit && !cap_clear) |=> (cap_count_reg == $past(cap_count_reg) + 32'h1)
      && (cap_value_reg == $past(i_enc_position)) && o_capture_pulse)
    else $error("capture not taken");

  a_cap_off : assert property (
    (cap_mode_reg == CAP_OFF) |=> !o_capture_pulse)
    else $error("capture while disabled");

  c_force_used   : cover property (ovr_en_reg[0] && inv_mask_reg[0]);
  c_cap_rise     : cover property (cap_mode_reg == CAP_RISE && cap_hit);
  c_cap_both_two : cover property (cap_mode_reg == CAP_BOTH && cap_hit ##[1:20] cap_hit);
  c_route_on     : cover property (route_reg[0] && o_input_state != cond_reg);

endmodule

/* test/dic_switch_model.sv */
// external switch model driving the pins of the conditioning block
// assumes the bench sets the wanted levels and the response speed
module dic_switch_model
#(
  parameter int N = 16
)
(
  input  wire logic         i_clk,
  input  wire logic         i_slow,
  input  wire logic [N-1:0] i_level,
  output logic      [N-1:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [N-1:0] lag_reg [3];
  always_ff @(posedge i_clk)
  begin
    lag_reg[0] <= i_level;
    lag_reg[1] <= lag_reg[0];
    lag_reg[2] <= lag_reg[1];
  end
  // a slow switch settles three cycles late
  assign o_pin = i_slow ? lag_reg[2] : i_level;
endmodule

/* test/tb_digital_input_conditioning.sv */
// self-checking bench of the digital input conditioning block
// assumes dic_top with 16 inputs and the switch model on the pins
module tb_digital_input_conditioning;
  timeunit 1ns;
  timeprecision 1ns;
  import dic_pkg::*;
  logic        clk = 1'b0;
  logic        nrst, step, wr, slow, cap, neg, pos, home, diff, route;
  logic [15:0] lvl, pin, routed, state, thr;
  logic [7:0]  idx;
  logic [31:0] enc, wdata, rdata;
  int          n_mismatch, total_checks, n_pulse;

  dic_switch_model #(.N(16)) sw (.i_clk(clk), .i_slow(slow), .i_level(lvl), .o_pin(pin));
  dic_top #(.N_IN(16)) dut (
    .i_pin_level(pin), .i_clk(clk), .i_nrst(nrst), .i_step_dir_mode(step),
    .i_routed_level(routed), .i_enc_position(enc), .i_reg_wr(wr), .i_reg_index(idx),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_input_state(state),
    .o_neg_limit(neg), .o_pos_limit(pos), .o_home_switch(home), .o_thresh_high(thr),
    .o_diff_receive(diff), .o_route_enable(route), .o_capture_pulse(cap));

  always #10 clk = ~clk;
  always @(posedge clk)
    if (cap === 1'b1) n_pulse++;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr = 1'b1;
    idx = a;
    wdata = d;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    idx = a;
    tick(1);
    check_word(rdata, exp);
  endtask

  task automatic t_regs;
    rd_check(IDX_HIGHEST, {24'h0, HIGHEST_RST});
    for (int i = 1; i < 9; i++)
    begin
      rd_check(8'(i), WORD_RST);
      if (i != 5)
      begin
        wr_reg(8'(i), 32'ha5c3_0f01);
        rd_check(8'(i), 32'ha5c3_0f01);
        wr_reg(8'(i), 32'h0);
      end
    end
    wr_reg(IDX_HIGHEST, 32'hff);
    rd_check(IDX_HIGHEST, 32'h08);
    wr_reg(IDX_RAW, 32'hffff);
    rd_check(IDX_RAW, 32'h0);
    wr_reg(8'h20, 32'h1234_5678);
    rd_check(8'h20, 32'h0);
  endtask

  task automatic t_force_invert;
    wr_reg(IDX_OVR_EN, 32'hfe);
    wr_reg(IDX_OVR_LVL, 32'h25a);
    wr_reg(IDX_INV_MASK, 32'h137);
    tick(3);
    check_word({16'h0, state}, 32'h16d);
    step = 1'b1;
    tick(3);
    check_word({16'h0, state}, 32'h16e);
    step = 1'b0;
    wr_reg(IDX_OVR_EN, 32'h0);
    wr_reg(IDX_OVR_LVL, 32'h0);
    wr_reg(IDX_INV_MASK, 32'h0);
  endtask

  task automatic t_pins;
    slow = 1'b1;
    lvl = 16'h8421;
    tick(12);
    check_word({16'h0, state}, 32'h8421);
    rd_check(IDX_RAW, 32'h8421);
    wr_reg(IDX_INV_MASK, 32'hffff);
    tick(3);
    check_word({16'h0, state}, 32'h7bde);
    wr_reg(IDX_INV_MASK, 32'h0);
    lvl = 16'h0;
    tick(12);
  endtask

  task automatic t_special;
    logic [31:0] m [5] = '{32'hffff_0000, 32'h1, 32'h2, 32'h4, 32'h7};
    wr_reg(IDX_OVR_EN, 32'h7);
    wr_reg(IDX_OVR_LVL, 32'h7);
    foreach (m[i])
    begin
      wr_reg(IDX_SF_MASK, m[i]);
      tick(2);
      check_word({29'h0, home, pos, neg}, {29'h0, m[i][2:0]});
    end
    wr_reg(IDX_SF_MASK, 32'h0);
    wr_reg(IDX_OVR_EN, 32'h1);
    wr_reg(IDX_OVR_LVL, 32'h0);
  endtask

  task automatic t_selects;
    wr_reg(IDX_RANGE, 32'h0001_8001);
    wr_reg(IDX_DIFF, 32'h1);
    tick(2);
    check_word({15'h0, diff, thr}, 32'h0001_8001);
    wr_reg(IDX_DIFF, 32'h2);
    routed = 16'h3c3c;
    wr_reg(IDX_ROUTE, 32'h1);
    tick(3);
    check_word({15'h0, diff, state}, 32'h3c3c);
    check_word({31'h0, route}, 32'h1);
    wr_reg(IDX_ROUTE, 32'h0);
    tick(3);
    check_word({15'h0, route, state}, 32'h0);
  endtask

  task automatic t_capture;
    logic [1:0]  md [4] = '{2'd1, 2'd2, 2'd3, 2'd0};
    logic [31:0] cnt, val;
    val = 32'h0;
    cnt = 32'h0;
    foreach (md[i])
    begin
      wr_reg(IDX_CAP_CTRL, {30'h0, md[i]});
      n_pulse = 0;
      if (md[i] != 2'd0) cnt = 32'h0;
      enc = 32'h1000 + i;
      wr_reg(IDX_OVR_LVL, 32'h1);
      tick(4);
      enc = 32'h2000 + i;
      wr_reg(IDX_OVR_LVL, 32'h0);
      tick(4);
      if (md[i][0]) val = 32'h1000 + i;
      if (md[i][1]) val = 32'h2000 + i;
      cnt = cnt + md[i][0] + md[i][1];
      check_word(32'(n_pulse), 32'(md[i][0]) + 32'(md[i][1]));
      rd_check(IDX_CAP_COUNT, cnt);
      rd_check(IDX_CAP_VALUE, val);
    end
    wr_reg(IDX_CAP_CTRL, 32'h5);
    rd_check(IDX_CAP_COUNT, cnt);
    wr_reg(IDX_CAP_CTRL, 32'h2);
    rd_check(IDX_CAP_COUNT, 32'h0);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    {nrst, step, wr, slow} = 4'h0;
    lvl = 16'h0;
    routed = 16'h0;
    idx = 8'h0;
    enc = 32'h0;
    wdata = 32'h0;
    tick(5);
    nrst = 1'b1;
    t_regs();
    t_force_invert();
    t_pins();
    t_special();
    t_selects();
    t_capture();
    complete_run();
  end
endmodule
